/* File: ssrd_regs.vh */
// register offsets, field positions, reset values for the supply supervisor
`ifndef SSRD_REGS_VH
`define SSRD_REGS_VH

// ------------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------------
`define SSRD_ADDR_HIGH_CTL    12'h000
`define SSRD_ADDR_LOW_CTL     12'h004
`define SSRD_ADDR_RIE         12'h008
`define SSRD_ADDR_CORE        12'h00c
`define SSRD_ADDR_STATUS      12'h010
`define SSRD_ADDR_MASK        12'h014

// ------------------------------------------------------------------
// reset values per silicon revision
// ------------------------------------------------------------------
`define SSRD_CTL_RST_ORIG     16'h4602
`define SSRD_CTL_RST_REV      16'h4400
`define SSRD_RIE_RST_ORIG     16'h1100
`define SSRD_RIE_RST_REV      16'h0000
`define SSRD_CORE_RST_ORIG    2'h2
`define SSRD_CORE_RST_REV     2'h0

// ------------------------------------------------------------------
// field positions and writable masks
// ------------------------------------------------------------------
`define SSRD_CTL_MON_EN       14
`define SSRD_CTL_SUP_EN       10
`define SSRD_CTL_DLY_ST       3
`define SSRD_CTL_LEVEL_LSB    0
`define SSRD_CTL_WMASK        16'hdfd7
`define SSRD_RIE_WMASK        16'h3377
`define SSRD_RIE_HIGH_RST     12
`define SSRD_RIE_LOW_RST      8
`define SSRD_RIE_HIGH_DLY_IE  4
`define SSRD_RIE_LOW_DLY_IE   0

// ------------------------------------------------------------------
// status bits and timing
// ------------------------------------------------------------------
`define SSRD_ST_HIGH_TRIP     0
`define SSRD_ST_LOW_TRIP      1
`define SSRD_ST_HIGH_DLY      2
`define SSRD_ST_LOW_DLY       3
`define SSRD_ST_WIDTH         4
`define SSRD_DLY_CYCLES       8'h20

`endif

/* File: ssrd_side.v */
// one supervisor side: level compare and settle-delay status
`timescale 1ns/1ps

module ssrd_side (
  // clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // configuration
  input  wire        sup_enable,
  input  wire [1:0]  sup_level,
  input  wire [1:0]  voltage_level,
  input  wire        level_written,
  // state
  output reg         trip,
  output reg         delay_status,
  output reg         delay_done
);

`include "ssrd_regs.vh"

  reg [7:0] dly_count;

  // below-level flag, registered to keep outputs clean
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      trip <= 1'b0;
    end else begin
      trip <= sup_enable && (voltage_level < sup_level);
    end
  end

  // settle delay after each control register write; status high while it runs
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dly_count    <= 8'h00;
      delay_status <= 1'b0;
      delay_done   <= 1'b0;
    end else begin
      delay_done <= 1'b0;
      if (level_written) begin
        dly_count    <= `SSRD_DLY_CYCLES;
        delay_status <= 1'b1;
      end else if (dly_count != 8'h00) begin
        dly_count <= dly_count - 8'h01;
        if (dly_count == 8'h01) begin
          delay_status <= 1'b0;
          delay_done   <= 1'b1;
        end
      end
    end
  end

endmodule

/* File: ssrd_supervisor.v */
// supply supervisor registers, reset defaults, reset request and interrupt
//
// Contract
// - original silicon: high-side control resets to 0x4602
// - revised silicon: high-side control resets to nominal 0x4400
// - low-side control resets 0x4602 original, 0x4400 revised
// - high supervisor enable bit 10 and monitor enable bit 14 reset one
// - low supervisor and monitor enables reset to one
// - original silicon: all supervisor and monitor levels default to two
// - reset/interrupt enable resets 0x1100 original, 0x0000 revised
// - enabled supervisor with voltage below level asserts power-on reset when its reset enable bit (12 high, 8 low) is set
// - reset enables bits 13,12,9,8; interrupt enables 6,5,4,2,1,0
// - high control bits 13,5 read zero; delay status bit 3 read-only
// - low control mirrors high layout, same reserved and read-only bits
// - revised silicon core level defaults zero, oscillator limit 8 MHz
// - original silicon core voltage level defaults to two (low byte 0x02)
`timescale 1ns/1ps

module ssrd_supervisor #(
  parameter ORIGINAL_SILICON = 1
) (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  // supply levels seen by the analog comparators
  input  wire [1:0]  high_voltage_level,
  input  wire [1:0]  low_voltage_level,
  // system outputs
  output reg         power_on_reset,
  output reg  [1:0]  core_voltage_level,
  output reg         high_osc_allowed,
  output reg         irq
);

`include "ssrd_regs.vh"

  // ------------------------------------------------------------------
  // revision-dependent reset values
  // ------------------------------------------------------------------
  localparam [15:0] CTL_RST  = ORIGINAL_SILICON ? `SSRD_CTL_RST_ORIG
                                                : `SSRD_CTL_RST_REV;
  localparam [15:0] RIE_RST  = ORIGINAL_SILICON ? `SSRD_RIE_RST_ORIG
                                                : `SSRD_RIE_RST_REV;
  localparam [1:0]  CORE_RST = ORIGINAL_SILICON ? `SSRD_CORE_RST_ORIG
                                                : `SSRD_CORE_RST_REV;

  reg  [15:0] high_supervisor_control;
  reg  [15:0] low_supervisor_control;
  reg  [15:0] supervisor_reset_interrupt_enable;
  reg  [`SSRD_ST_WIDTH-1:0] event_status;
  reg  [`SSRD_ST_WIDTH-1:0] event_mask;
  reg  [`SSRD_ST_WIDTH-1:0] next_status;
  reg  [31:0] next_prdata;
  reg         addr_ok;

  wire        high_trip;
  wire        low_trip;
  wire        high_delay_status;
  wire        low_delay_status;
  wire        high_delay_done;
  wire        low_delay_done;

  wire setup   = psel && !penable;
  wire wr_take = psel && penable && pready && pwrite;
  wire wr_high = wr_take && (paddr == `SSRD_ADDR_HIGH_CTL);
  wire wr_low  = wr_take && (paddr == `SSRD_ADDR_LOW_CTL);
  wire wr_rie  = wr_take && (paddr == `SSRD_ADDR_RIE);
  wire wr_core = wr_take && (paddr == `SSRD_ADDR_CORE);
  wire wr_stat = wr_take && (paddr == `SSRD_ADDR_STATUS);
  wire wr_mask = wr_take && (paddr == `SSRD_ADDR_MASK);

  // ------------------------------------------------------------------
  // supervisor sides
  // ------------------------------------------------------------------
  ssrd_side u_high (
    .pclk          (pclk),
    .presetn       (presetn),
    .sup_enable    (high_supervisor_control[`SSRD_CTL_SUP_EN]),
    .sup_level     (high_supervisor_control[1:0]),
    .voltage_level (high_voltage_level),
    .level_written (wr_high),
    .trip          (high_trip),
    .delay_status  (high_delay_status),
    .delay_done    (high_delay_done)
  );

  ssrd_side u_low (
    .pclk          (pclk),
    .presetn       (presetn),
    .sup_enable    (low_supervisor_control[`SSRD_CTL_SUP_EN]),
    .sup_level     (low_supervisor_control[1:0]),
    .voltage_level (low_voltage_level),
    .level_written (wr_low),
    .trip          (low_trip),
    .delay_status  (low_delay_status),
    .delay_done    (low_delay_done)
  );

  // ------------------------------------------------------------------
  // supervisor control registers
  // ------------------------------------------------------------------
  // reserved and read-only bits masked off on write so they stay zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_supervisor_control <= CTL_RST;
    end else if (wr_high) begin
      high_supervisor_control <= pwdata[15:0] & `SSRD_CTL_WMASK;
    end
  end

  // low side shares the high-side layout and write mask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_supervisor_control <= CTL_RST;
    end else if (wr_low) begin
      low_supervisor_control <= pwdata[15:0] & `SSRD_CTL_WMASK;
    end
  end

  // reset and interrupt enables; reserved bits never store
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      supervisor_reset_interrupt_enable <= RIE_RST;
    end else if (wr_rie) begin
      supervisor_reset_interrupt_enable <=
        pwdata[15:0] & `SSRD_RIE_WMASK;
    end
  end

  // ------------------------------------------------------------------
  // core voltage level
  // ------------------------------------------------------------------
  wire        core_step_up;
  wire        core_step_down;

  // single steps only; the guards stop 3 to 0 and 0 to 3 from wrapping
  assign core_step_up   = (core_voltage_level != 2'd3) &&
                          (pwdata[1:0] == core_voltage_level + 2'd1);
  assign core_step_down = (core_voltage_level != 2'd0) &&
                          (pwdata[1:0] == core_voltage_level - 2'd1);

  // larger jumps are dropped silently, the bus reports no error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_voltage_level <= CORE_RST;
    end else if (wr_core && (core_step_up || core_step_down)) begin
      core_voltage_level <= pwdata[1:0];
    end
  end

  // ------------------------------------------------------------------
  // event mask
  // ------------------------------------------------------------------
  // a set mask bit keeps its status bit off the interrupt line
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_mask <= {`SSRD_ST_WIDTH{1'b0}};
    end else if (wr_mask) begin
      event_mask <= pwdata[`SSRD_ST_WIDTH-1:0];
    end
  end

  // ------------------------------------------------------------------
  // sticky events, write one to clear; a new event beats the clear
  // ------------------------------------------------------------------
  reg  [`SSRD_ST_WIDTH-1:0] status_set;
  wire [`SSRD_ST_WIDTH-1:0] status_clear;

  // trips always record; delay completion only when its enable is set
  always @* begin
    status_set                     = {`SSRD_ST_WIDTH{1'b0}};
    status_set[`SSRD_ST_HIGH_TRIP] = high_trip;
    status_set[`SSRD_ST_LOW_TRIP]  = low_trip;
    status_set[`SSRD_ST_HIGH_DLY]  = high_delay_done &
      supervisor_reset_interrupt_enable[`SSRD_RIE_HIGH_DLY_IE];
    status_set[`SSRD_ST_LOW_DLY]   = low_delay_done &
      supervisor_reset_interrupt_enable[`SSRD_RIE_LOW_DLY_IE];
  end

  // only the bits written as one are cleared
  assign status_clear = wr_stat ? pwdata[`SSRD_ST_WIDTH-1:0]
                                : {`SSRD_ST_WIDTH{1'b0}};

  // clear first, then set, so an event in the clear cycle is kept
  always @* begin
    next_status = (event_status & ~status_clear) | status_set;
  end

  // status register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      event_status <= {`SSRD_ST_WIDTH{1'b0}};
    end else begin
      event_status <= next_status;
    end
  end

  // ------------------------------------------------------------------
  // reset request
  // ------------------------------------------------------------------
  // a level held while any enabled trip lasts, not a pulse
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_on_reset <= 1'b0;
    end else begin
      power_on_reset <=
        (high_trip &
         supervisor_reset_interrupt_enable[`SSRD_RIE_HIGH_RST]) |
        (low_trip &
         supervisor_reset_interrupt_enable[`SSRD_RIE_LOW_RST]);
    end
  end

  // ------------------------------------------------------------------
  // oscillator limit and interrupt
  // ------------------------------------------------------------------
  // flag follows the core level one cycle late, kept as a flop output
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      high_osc_allowed <= 1'b0;
    end else begin
      high_osc_allowed <= (core_voltage_level != 2'd0);
    end
  end

  // built from next status so it rises in the same cycle as the bit
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(next_status & ~event_mask);
    end
  end

  // ------------------------------------------------------------------
  // apb read path, no wait state; reads come from flops loaded in setup
  // ------------------------------------------------------------------
  // control views carry the live delay status in the read-only bit
  wire [15:0] high_ctl_view = {high_supervisor_control[15:4],
                               high_delay_status,
                               high_supervisor_control[2:0]};
  wire [15:0] low_ctl_view  = {low_supervisor_control[15:4],
                               low_delay_status,
                               low_supervisor_control[2:0]};

  // read mux; anything off the word map reads zero and flags an error
  always @* begin
    next_prdata = 32'h0000_0000;
    addr_ok     = 1'b1;
    case (paddr)
      `SSRD_ADDR_HIGH_CTL: begin
        next_prdata = {16'h0000, high_ctl_view};
      end
      `SSRD_ADDR_LOW_CTL: begin
        next_prdata = {16'h0000, low_ctl_view};
      end
      `SSRD_ADDR_RIE: begin
        next_prdata = {16'h0000, supervisor_reset_interrupt_enable};
      end
      `SSRD_ADDR_CORE: begin
        next_prdata = {30'h0, core_voltage_level};
      end
      `SSRD_ADDR_STATUS: begin
        next_prdata = {28'h0, event_status};
      end
      `SSRD_ADDR_MASK: begin
        next_prdata = {28'h0, event_mask};
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // ------------------------------------------------------------------
  // apb response
  // ------------------------------------------------------------------
  // ready one cycle after every setup; error only off the word map
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !addr_ok;
    end
  end

  // read data holds until the next read, so a late master still sees it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup && !pwrite) begin
      prdata <= next_prdata;
    end
  end

endmodule

/* File: ssrd_supervisor_properties.sv */
// concurrent checks on the supply supervisor top-level ports
`timescale 1ns/1ps

module ssrd_supervisor_properties (
  // apb side
  input logic        pclk,
  input logic        presetn,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic [31:0] prdata,
  input logic        pready,
  input logic        pslverr,
  // supplies and system outputs
  input logic [1:0]  high_voltage_level,
  input logic [1:0]  low_voltage_level,
  input logic        power_on_reset,
  input logic [1:0]  core_voltage_level,
  input logic        high_osc_allowed,
  input logic        irq
);
  // -----------------------------------------------------------------
  // one clock domain, so one default clock and disable
  // -----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // bus handshake: one wait-free access, error only off the map
  a_ready_after_setup: assert property (psel && !penable |=> pready)
    else $error("no pready after setup");
  a_ready_one_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_unmapped_err: assert property (pready |-> pslverr ==
    (paddr[1:0] != 2'b00 || paddr > 12'h014))
    else $error("pslverr does not match address");
  a_err_reads_zero: assert property (pready && pslverr && !pwrite
    |-> prdata == 32'h0) else $error("unmapped read not zero");
  // reserved bits of the three supervisor registers read zero
  a_ctl_reserved_zero: assert property (
    pready && !pwrite && paddr <= 12'h004
    |-> !prdata[13] && !prdata[5] && prdata[31:16] == 16'h0)
    else $error("control reserved bit set");
  a_rie_reserved_zero: assert property (
    pready && !pwrite && paddr == 12'h008 |-> (prdata & ~32'h3377) == 0)
    else $error("enable reserved bit set");
  // oscillator limit follows a settled core level
  a_osc_limit: assert property (
    $past(presetn) && $stable(core_voltage_level)
    |-> high_osc_allowed == (core_voltage_level != 2'h0))
    else $error("oscillator limit wrong for core level");
  // core level only ever moves one step
  a_core_one_step: assert property (
    $past(presetn) && !$stable(core_voltage_level)
    |-> {1'b0, core_voltage_level} ==
        {1'b0, $past(core_voltage_level)} + 3'h1
    || {1'b0, core_voltage_level} + 3'h1 ==
       {1'b0, $past(core_voltage_level)})
    else $error("core level jumped");
  // reset request needs a supply below the top level
  a_por_cause: assert property ($rose(power_on_reset)
    |-> $past(high_voltage_level, 2) != 2'h3
    || $past(low_voltage_level, 2) != 2'h3
    || $past(high_voltage_level) != 2'h3
    || $past(low_voltage_level) != 2'h3)
    else $error("reset request without low supply");
  a_por_release: assert property (
    (high_voltage_level == 2'h3 && low_voltage_level == 2'h3)[*4]
    |-> !power_on_reset) else $error("reset request stuck");
endmodule

bind ssrd_supervisor ssrd_supervisor_properties ssrd_supervisor_properties_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
  .pready, .pslverr, .high_voltage_level, .low_voltage_level,
  .power_on_reset, .core_voltage_level, .high_osc_allowed, .irq);

/* File: testbench.sv */
// self-checking bench for the supply supervisor register block
`timescale 1ns/1ps

module testbench;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rv;
  logic [31:0] prdata_rev, rv_rev;
  logic        pready, pslverr, por, osc, irq, ev, osc_rev;
  logic [1:0]  hv = 2'h3, lv = 2'h3, core;
  int          bad_count = 0, checks = 0;
  // reset rows: address, expected read original, expected read revised
  logic [75:0] rows [7] = '{{12'h000, 32'h4602, 32'h4400},
    {12'h004, 32'h4602, 32'h4400}, {12'h008, 32'h1100, 32'h0000},
    {12'h00c, 32'h0002, 32'h0000}, {12'h010, 32'h0, 32'h0},
    {12'h014, 32'h0, 32'h0}, {12'h018, 32'h0, 32'h0}};

  // free-running bus clock
  always #12.5 pclk = ~pclk;

  ssrd_supervisor #(.ORIGINAL_SILICON(1)) ssrd_supervisor_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .high_voltage_level(hv), .low_voltage_level(lv),
    .power_on_reset(por), .core_voltage_level(core),
    .high_osc_allowed(osc), .irq);

  // revised silicon shares the bus; only its defaults are checked
  ssrd_supervisor #(.ORIGINAL_SILICON(0)) ssrd_supervisor_rev_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata(prdata_rev), .pready(), .pslverr(), .high_voltage_level(hv),
    .low_voltage_level(lv), .power_on_reset(), .core_voltage_level(),
    .high_osc_allowed(osc_rev), .irq());

  // -----------------------------------------------------------------
  // shared tasks
  // -----------------------------------------------------------------
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one transfer; no fixed latency assumed, bounded wait instead
  task apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1; penable <= 0; paddr <= a; pwrite <= w; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n == 20) chk(32'h0, 32'h1);
    rv = prdata;
    rv_rev = prdata_rev;
    ev = pslverr;
    psel <= 0; penable <= 0;
  endtask

  task rd(input logic [11:0] a, input logic [31:0] e);
    apb(a, 1'b0, 32'h0);
    chk(rv, e);
  endtask

  task reset_rows;
    for (int i = 0; i < 7; i++) begin
      rd(rows[i][75:64], rows[i][63:32]);
      chk(rv_rev, rows[i][31:0]);
      chk(ev, rows[i][75:64] == 12'h018);
    end
    chk(osc_rev, 0);
    chk(osc, 1);
    $display("reset values done");
  endtask

  task close_out;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // -----------------------------------------------------------------
  // main sequence
  // -----------------------------------------------------------------
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1;
    reset_rows;
    // all-ones writes: reserved bits drop, delay status reads busy
    apb(12'h008, 1'b1, 32'hffff);
    rd(12'h008, 32'h3377);
    for (int s = 0; s < 2; s++) begin
      apb({s[9:0], 2'b00}, 1'b1, 32'hffff);
      rd({s[9:0], 2'b00}, 32'hdfdf);
    end
    repeat (40) @(posedge pclk);
    rd(12'h000, 32'hdfd7);
    rd(12'h004, 32'hdfd7);
    $display("reserved bits done");
    rd(12'h010, 32'h000c);
    chk(irq, 1);
    // mask, then clear; irq is registered so let it settle
    apb(12'h014, 1'b1, 32'h000c);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    apb(12'h010, 1'b1, 32'h000c);
    rd(12'h010, 32'h0);
    apb(12'h014, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(irq, 0);
    $display("interrupt test done");
    // drop each supply under its level with its reset enable set
    for (int s = 0; s < 2; s++) begin
      if (s == 0) hv <= 2'h0;
      else lv <= 2'h0;
      repeat (4) @(posedge pclk);
      chk(por, 1);
      chk(irq, 1);
      hv <= 2'h3;
      lv <= 2'h3;
      repeat (4) @(posedge pclk);
      chk(por, 0);
      rd(12'h010, 32'h1 << s);
      apb(12'h010, 1'b1, 32'h1 << s);
    end
    $display("trip test done");
    // a jump of two is ignored; single steps reach zero
    apb(12'h00c, 1'b1, 32'h0);
    rd(12'h00c, 32'h2);
    apb(12'h00c, 1'b1, 32'h1);
    apb(12'h00c, 1'b1, 32'h0);
    repeat (2) @(posedge pclk);
    chk(core, 0);
    chk(osc, 0);
    apb(12'h00c, 1'b1, 32'h1);
    repeat (2) @(posedge pclk);
    chk(osc, 1);
    $display("core level done");
    // second reset in mid-run restores every default
    presetn <= 0;
    repeat (3) @(posedge pclk);
    presetn <= 1;
    reset_rows;
    close_out;
  end

  // watchdog, far beyond the few hundred cycles the tests need
  initial begin
    #100us;
    bad_count++;
    close_out;
  end
endmodule
